/* File: dsau_regs.svh */
// Address map, offsets and constants of the data-space access unit.
`ifndef DSAU_REGS_SVH
`define DSAU_REGS_SVH

// ----------------------------------------------------------------------
// Working registers mapped into the data space.
// ----------------------------------------------------------------------
`define DSAU_WORK_REG_0_OFS 16'h0000
`define DSAU_WORK_REG_1_OFS 16'h0005
`define DSAU_WORK_REG_2_OFS 16'h0004
`define DSAU_WORK_REG_3_OFS 16'h9000
`define DSAU_WORK_REG_4_OFS 16'h8000
`define DSAU_WORK_REG_5_OFS 16'h000a
`define DSAU_WORK_REG_6_OFS 16'h000c
`define DSAU_WORK_REG_7_OFS 16'h3000
`define DSAU_WREG_RST 16'h0000
`define DSAU_NUM_WREG 8

// ----------------------------------------------------------------------
// Data space regions.
// ----------------------------------------------------------------------
`define DSAU_SFR_HI 16'h07ff
`define DSAU_NEAR_HI 16'h1fff
`define DSAU_RAM_LO 16'h0800
`define DSAU_RAM_HI 16'h27ff
`define DSAU_EDS_LO 16'h8000
// One bit per 32-byte control-register region, set where one exists.
`define DSAU_SFR_IMPL_MAP 64'h0c77_b040_67e7_6f7f
`define DSAU_REGION_LSB 5
`define DSAU_REGION_MSB 10
`define DSAU_NEAR_BITS 13

// ----------------------------------------------------------------------
// Pointer steps and byte lanes.
// ----------------------------------------------------------------------
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
`define DSAU_SIGN_BIT 7
`define DSAU_BYTE_ZERO 8'h00
`define DSAU_BYTE_ONES 8'hff
`define DSAU_WORD_ZERO 16'h0000

`endif

/* File: dsau_pkg.sv */
// Types shared by the data-space access unit modules.
package dsau_pkg;

  // Address mode of an access, Gray coded.
  typedef enum logic [1:0] {
    DSAU_MODE_INDIRECT = 2'b00,
    DSAU_MODE_POSTINC = 2'b01,
    DSAU_MODE_NEAR = 2'b11,
    DSAU_MODE_FULL = 2'b10
  } dsau_mode_type;

  // Working register operation, Gray coded.
  typedef enum logic [2:0] {
    DSAU_OP_NONE = 3'b000,
    DSAU_OP_LOAD_WORD = 3'b001,
    DSAU_OP_LOAD_BYTE = 3'b011,
    DSAU_OP_SIGN_EXT = 3'b010,
    DSAU_OP_ZERO_EXT = 3'b110
  } dsau_regop_type;

  // Where a read answer comes from.
  typedef enum logic [2:0] {
    DSAU_SRC_ZERO = 3'b000,
    DSAU_SRC_RAM = 3'b001,
    DSAU_SRC_PER = 3'b011,
    DSAU_SRC_EDS = 3'b010,
    DSAU_SRC_WREG = 3'b110
  } dsau_src_type;

endpackage

/* File: dsau_lane.sv */
// Byte lane steering for reads and writes of the data space.
`timescale 1ns/1ps
`default_nettype none
`include "dsau_regs.svh"
module dsau_lane (
  input wire logic [15:0] rd_word_in,
  input wire logic rd_byte_in,
  input wire logic rd_a0_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_byte_in,
  input wire logic wr_a0_in,
  output logic [15:0] rd_data_out,
  output logic [15:0] wr_word_out,
  output logic wr_lo_out,
  output logic wr_hi_out
);
  // Selected byte always lands on the low lane, upper lane reads zero.
  wire logic [7:0] rd_sel_byte = rd_a0_in ? rd_word_in[15:8] :
                                            rd_word_in[7:0];
  assign rd_data_out = rd_byte_in ? {`DSAU_BYTE_ZERO, rd_sel_byte} :
                                    rd_word_in;
  // A byte write is copied to both lanes; only one strobe fires.
  assign wr_word_out = wr_byte_in ? {wr_data_in[7:0], wr_data_in[7:0]} :
                                    wr_data_in;
  assign wr_lo_out = !wr_byte_in || !wr_a0_in;
  assign wr_hi_out = !wr_byte_in || wr_a0_in;
endmodule
`default_nettype wire

/* File: dsau_decode.sv */
// Data space address decode: regions and mapped working registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsau_regs.svh"
module dsau_decode (
  input wire logic [15:0] addr_in,
  output logic sfr_out,
  output logic sfr_impl_out,
  output logic ram_out,
  output logic eds_out,
  output logic wreg_hit_out,
  output logic [2:0] wreg_idx_out
);
  localparam logic [15:0] WREG_OFS [`DSAU_NUM_WREG] = '{
    `DSAU_WORK_REG_0_OFS, `DSAU_WORK_REG_1_OFS, `DSAU_WORK_REG_2_OFS, `DSAU_WORK_REG_3_OFS,
    `DSAU_WORK_REG_4_OFS, `DSAU_WORK_REG_5_OFS, `DSAU_WORK_REG_6_OFS, `DSAU_WORK_REG_7_OFS};
  localparam logic [63:0] IMPL_MAP = `DSAU_SFR_IMPL_MAP;

  // Region decode on the byte address.
  wire logic [5:0] region = addr_in[`DSAU_REGION_MSB:`DSAU_REGION_LSB];
  assign sfr_out = addr_in <= `DSAU_SFR_HI;
  assign sfr_impl_out = sfr_out && IMPL_MAP[region];
  assign ram_out = addr_in >= `DSAU_RAM_LO && addr_in <= `DSAU_RAM_HI;
  assign eds_out = addr_in >= `DSAU_EDS_LO;

  // Working registers match on the word address; lowest number wins.
  logic [`DSAU_NUM_WREG-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < `DSAU_NUM_WREG; gi++) begin : g_hit
      assign hit[gi] = addr_in[15:1] == WREG_OFS[gi][15:1];
    end
  endgenerate
  assign wreg_hit_out = |hit;
  always_comb begin
    wreg_idx_out = 3'h0;
    for (int i = `DSAU_NUM_WREG - 1; i >= 0; i--) begin
      if (hit[i]) begin
        wreg_idx_out = 3'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: dsau_top.sv */
// Data-space access unit: addressing, byte lanes, decode, working regs.
//
// Behaviour
// - Word of two bytes, low byte even address.
// - Post-increment adds one per byte, two per word.
// - Byte read selects by bit 0, low lane.
// - Shared word decode, separate byte write strobes.
// - Odd word address raises address error trap.
// - Misaligned read completes; misaligned write suppressed.
// - Byte load keeps the register's high byte.
// - Sign extend copies bit 7 upward.
// - Zero extend clears the high byte.
// - Near region reached by 13-bit direct field.
// - Move reaches whole space by 16-bit field.
// - Low 2 Kbytes decode as control registers.
// - Unimplemented control addresses read as zero.
// - Control registers tracked in 32-byte regions.
// - Data RAM occupies 0800h to 27FFh.
// - Upper half decodes as extended data window.
`timescale 1ns/1ps
`default_nettype none
`include "dsau_regs.svh"
module dsau_top (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Access request.
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire dsau_pkg::dsau_mode_type req_mode_in,
  input wire logic [2:0] req_ptr_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  // Working register operation.
  input wire dsau_pkg::dsau_regop_type reg_op_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [15:0] reg_data_in,
  input wire logic [2:0] reg_rd_sel_in,
  // Read words, valid while their enable is high.
  input wire logic [15:0] ram_rdata_in,
  input wire logic [15:0] per_rdata_in,
  input wire logic [15:0] eds_rdata_in,
  // Data RAM port.
  output logic ram_en_out,
  output logic ram_wr_lo_out,
  output logic ram_wr_hi_out,
  output logic [14:0] ram_addr_out,
  output logic [15:0] ram_wdata_out,
  // Control-register port.
  output logic per_en_out,
  output logic per_wr_lo_out,
  output logic per_wr_hi_out,
  output logic [14:0] per_addr_out,
  output logic [15:0] per_wdata_out,
  // Extended data window port.
  output logic eds_en_out,
  output logic eds_wr_lo_out,
  output logic eds_wr_hi_out,
  output logic [14:0] eds_addr_out,
  output logic [15:0] eds_wdata_out,
  // Read answer and register read port.
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  output logic [15:0] reg_rdata_out,
  // Exception event.
  output logic addr_err_out,
  output logic addr_err_wr_out
);
  import dsau_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic [15:0] wreg_r [`DSAU_NUM_WREG];
  logic ram_en_r, ram_wr_lo_r, ram_wr_hi_r;
  logic per_en_r, per_wr_lo_r, per_wr_hi_r;
  logic eds_en_r, eds_wr_lo_r, eds_wr_hi_r;
  logic [14:0] word_addr_r;
  logic [15:0] wdata_r;
  logic rd_valid_r;
  logic [15:0] rd_data_r, reg_rdata_r;
  logic addr_err_r, addr_err_wr_r;
  logic p1_rd_r, p1_byte_r, p1_a0_r;
  dsau_src_type p1_src_r;
  logic [15:0] p1_wreg_r;
  logic sfr_hit, sfr_impl, ram_hit, eds_hit, wreg_hit;
  logic [2:0] wreg_idx;
  logic [15:0] lane_rd, lane_wr;
  logic lane_lo, lane_hi;

  // ----------------------------------------------------------------------
  // Effective address generation.
  // ----------------------------------------------------------------------
  // Near mode carries only 13 address bits, so it cannot leave 0000h-1FFFh.
  wire logic [15:0] near_ea = {3'h0, req_addr_in[`DSAU_NEAR_BITS-1:0]};
  wire logic [15:0] ptr_val = wreg_r[req_ptr_in];
  wire logic indirect = req_mode_in == DSAU_MODE_INDIRECT ||
                        req_mode_in == DSAU_MODE_POSTINC;
  // Full mode takes the whole 16-bit field.
  wire logic [15:0] ea = indirect ? ptr_val :
                         (req_mode_in == DSAU_MODE_NEAR) ? near_ea :
                         req_addr_in;

  // Step through byte-addressed memory by the operand size.
  wire logic [15:0] ptr_step = req_byte_in ? `DSAU_STEP_BYTE :
                                             `DSAU_STEP_WORD;
  wire logic ptr_inc = req_valid_in && req_mode_in == DSAU_MODE_POSTINC;
  wire logic [15:0] ptr_next = 16'(ptr_val + ptr_step);

  // ----------------------------------------------------------------------
  // Alignment check.
  // ----------------------------------------------------------------------
  // A word access must sit at an even byte address.
  wire logic misaligned = req_valid_in && !req_byte_in && ea[0];
  // A misaligned write is dropped: no port enable and no lane strobe.
  wire logic do_write = req_valid_in && req_write_in && !misaligned;
  // A misaligned read is still carried out on the containing word.
  wire logic do_read = req_valid_in && !req_write_in;

  // ----------------------------------------------------------------------
  // Address decode and lane steering.
  // ----------------------------------------------------------------------
  dsau_decode u_decode (
    .addr_in(ea),
    .sfr_out(sfr_hit),
    .sfr_impl_out(sfr_impl),
    .ram_out(ram_hit),
    .eds_out(eds_hit),
    .wreg_hit_out(wreg_hit),
    .wreg_idx_out(wreg_idx)
  );

  // Word of stage 1, picked by where the access landed.
  wire logic [15:0] p1_word = (p1_src_r == DSAU_SRC_RAM) ? ram_rdata_in :
                              (p1_src_r == DSAU_SRC_PER) ? per_rdata_in :
                              (p1_src_r == DSAU_SRC_EDS) ? eds_rdata_in :
                              (p1_src_r == DSAU_SRC_WREG) ? p1_wreg_r :
                              `DSAU_WORD_ZERO;

  dsau_lane u_lane (
    .rd_word_in(p1_word),
    .rd_byte_in(p1_byte_r),
    .rd_a0_in(p1_a0_r),
    .wr_data_in(req_wdata_in),
    .wr_byte_in(req_byte_in),
    .wr_a0_in(ea[0]),
    .rd_data_out(lane_rd),
    .wr_word_out(lane_wr),
    .wr_lo_out(lane_lo),
    .wr_hi_out(lane_hi)
  );

  // Target selection; mapped working registers shadow every region.
  wire logic tgt_wreg = wreg_hit;
  wire logic tgt_eds = !wreg_hit && eds_hit;
  wire logic tgt_ram = !wreg_hit && ram_hit;
  // Only regions that hold real registers reach the control port.
  wire logic tgt_per = !wreg_hit && sfr_impl;
  wire dsau_src_type src_nxt = tgt_wreg ? DSAU_SRC_WREG :
                               tgt_eds ? DSAU_SRC_EDS :
                               tgt_ram ? DSAU_SRC_RAM :
                               tgt_per ? DSAU_SRC_PER :
                               DSAU_SRC_ZERO;
  // Empty control regions read zero.
  wire logic unused_sfr = sfr_hit && !sfr_impl;

  // Per-lane strobes shared by every target.
  wire logic wr_lo_nxt = do_write && lane_lo;
  wire logic wr_hi_nxt = do_write && lane_hi;

  // ----------------------------------------------------------------------
  // Memory port strobes.
  // ----------------------------------------------------------------------
  // Enables last one cycle; the word address drops byte address bit 0.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ram_en_r <= 1'b0;
      ram_wr_lo_r <= 1'b0;
      ram_wr_hi_r <= 1'b0;
      per_en_r <= 1'b0;
      per_wr_lo_r <= 1'b0;
      per_wr_hi_r <= 1'b0;
      eds_en_r <= 1'b0;
      eds_wr_lo_r <= 1'b0;
      eds_wr_hi_r <= 1'b0;
    end else begin
      ram_en_r <= tgt_ram && (do_read || do_write);
      ram_wr_lo_r <= tgt_ram && wr_lo_nxt;
      ram_wr_hi_r <= tgt_ram && wr_hi_nxt;
      per_en_r <= tgt_per && (do_read || do_write);
      per_wr_lo_r <= tgt_per && wr_lo_nxt;
      per_wr_hi_r <= tgt_per && wr_hi_nxt;
      eds_en_r <= tgt_eds && (do_read || do_write);
      eds_wr_lo_r <= tgt_eds && wr_lo_nxt;
      eds_wr_hi_r <= tgt_eds && wr_hi_nxt;
    end
  end

  // Address and data are shared by the three ports.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_addr_r <= 15'h0000;
      wdata_r <= `DSAU_WORD_ZERO;
    end else begin
      word_addr_r <= ea[15:1];
      wdata_r <= lane_wr;
    end
  end

  // ----------------------------------------------------------------------
  // Read pipeline.
  // ----------------------------------------------------------------------
  // Stage 1 keeps what stage 2 needs to align the byte.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      p1_rd_r <= 1'b0;
      p1_byte_r <= 1'b0;
      p1_a0_r <= 1'b0;
      p1_src_r <= DSAU_SRC_ZERO;
      p1_wreg_r <= `DSAU_WORD_ZERO;
    end else begin
      p1_rd_r <= do_read;
      p1_byte_r <= req_byte_in;
      p1_a0_r <= ea[0];
      p1_src_r <= unused_sfr ? DSAU_SRC_ZERO : src_nxt;
      p1_wreg_r <= wreg_r[wreg_idx];
    end
  end

  // Stage 2 holds the answer for one cycle per read.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= `DSAU_WORD_ZERO;
    end else begin
      rd_valid_r <= p1_rd_r;
      rd_data_r <= p1_rd_r ? lane_rd : `DSAU_WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // Address error event.
  // ----------------------------------------------------------------------
  // One pulse per fault, flagged if a write caused it.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_err_r <= 1'b0;
      addr_err_wr_r <= 1'b0;
    end else begin
      addr_err_r <= misaligned;
      addr_err_wr_r <= misaligned && req_write_in;
    end
  end

  // ----------------------------------------------------------------------
  // Working registers.
  // ----------------------------------------------------------------------
  // Priority per register: execution-unit operation, then mapped write,
  // then post-increment. A clash is a sequencing fault upstream, so the
  // cheap fixed order is preferred to stalling.
  genvar gi;
  generate
    for (gi = 0; gi < `DSAU_NUM_WREG; gi++) begin : g_wreg
      logic [15:0] cur;
      logic [15:0] wreg_nxt;
      logic op_hit, map_lo, map_hi, inc_hit;
      assign cur = wreg_r[gi];
      assign op_hit = reg_op_in != DSAU_OP_NONE && reg_sel_in == 3'(gi);
      assign map_lo = tgt_wreg && wreg_idx == 3'(gi) && wr_lo_nxt;
      assign map_hi = tgt_wreg && wreg_idx == 3'(gi) && wr_hi_nxt;
      assign inc_hit = ptr_inc && req_ptr_in == 3'(gi);

      always_comb begin
        wreg_nxt = cur;
        if (op_hit) begin
          case (reg_op_in)
            DSAU_OP_LOAD_WORD: begin
              wreg_nxt = reg_data_in;
            end
            DSAU_OP_LOAD_BYTE: begin
              wreg_nxt = {cur[15:8], reg_data_in[7:0]};
            end
            DSAU_OP_SIGN_EXT: begin
              wreg_nxt = {cur[`DSAU_SIGN_BIT] ? `DSAU_BYTE_ONES :
                          `DSAU_BYTE_ZERO, cur[7:0]};
            end
            DSAU_OP_ZERO_EXT: begin
              wreg_nxt = {`DSAU_BYTE_ZERO, cur[7:0]};
            end
            default: begin
              wreg_nxt = cur;
            end
          endcase
        end else if (map_lo || map_hi) begin
          // Only the strobed lane changes, as for memory.
          wreg_nxt = {map_hi ? lane_wr[15:8] : cur[15:8],
                      map_lo ? lane_wr[7:0] : cur[7:0]};
        end else if (inc_hit) begin
          wreg_nxt = ptr_next;
        end
      end

      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          wreg_r[gi] <= `DSAU_WREG_RST;
        end else begin
          wreg_r[gi] <= wreg_nxt;
        end
      end
    end
  endgenerate

  // Register read port, one cycle behind its select.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_r <= `DSAU_WORD_ZERO;
    end else begin
      reg_rdata_r <= wreg_r[reg_rd_sel_in];
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign ram_en_out = ram_en_r;
  assign ram_wr_lo_out = ram_wr_lo_r;
  assign ram_wr_hi_out = ram_wr_hi_r;
  assign ram_addr_out = word_addr_r;
  assign ram_wdata_out = wdata_r;
  assign per_en_out = per_en_r;
  assign per_wr_lo_out = per_wr_lo_r;
  assign per_wr_hi_out = per_wr_hi_r;
  assign per_addr_out = word_addr_r;
  assign per_wdata_out = wdata_r;
  assign eds_en_out = eds_en_r;
  assign eds_wr_lo_out = eds_wr_lo_r;
  assign eds_wr_hi_out = eds_wr_hi_r;
  assign eds_addr_out = word_addr_r;
  assign eds_wdata_out = wdata_r;
  assign rd_valid_out = rd_valid_r;
  assign rd_data_out = rd_data_r;
  assign reg_rdata_out = reg_rdata_r;
  assign addr_err_out = addr_err_r;
  assign addr_err_wr_out = addr_err_wr_r;
endmodule
`default_nettype wire

/* File: dsau_checker.sv */
// Port-level assertions for the data-space access unit.
`timescale 1ns/1ps
`default_nettype none
module dsau_checker (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire dsau_pkg::dsau_mode_type req_mode_in,
  input wire logic [15:0] req_addr_in,
  input wire logic ram_en_out,
  input wire logic ram_wr_lo_out,
  input wire logic ram_wr_hi_out,
  input wire logic [14:0] ram_addr_out,
  input wire logic per_en_out,
  input wire logic eds_en_out,
  input wire logic rd_valid_out,
  input wire logic [15:0] rd_data_out,
  input wire logic addr_err_out,
  input wire logic addr_err_wr_out
);
  import dsau_pkg::*;
  // ------
  // Request classes seen at the access port.
  // ------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Direct modes have mode bit 1; EA bit 0 is the field's.
  wire direct = req_valid_in && req_mode_in[1];
  wire full = req_valid_in && (req_mode_in == DSAU_MODE_FULL);
  // A misaligned word write enables no port.
  wire wr_bad = req_write_in && !req_byte_in && req_addr_in[0];
  wire ram_hit = full && req_addr_in >= 16'h0800 && req_addr_in <= 16'h27ff;
  wire near_ram = req_valid_in && (req_mode_in == DSAU_MODE_NEAR) &&
    !wr_bad && req_addr_in[12:0] >= 13'h0800;
  sequence s_ram_rd;
    ram_hit && !req_write_in;
  endsequence
  sequence s_ram_en;
    ram_en_out && !per_en_out && !eds_en_out;
  endsequence
  sequence s_answer;
    rd_valid_out;
  endsequence
  AST_RD_LATENCY: assert property (s_ram_rd |=> s_ram_en ##1 s_answer)
    else $error("ram read answer late or missing");
  AST_BYTE_LANE: assert property (ram_hit && req_write_in && req_byte_in |=>
    ram_wr_lo_out != $past(req_addr_in[0]) &&
    ram_wr_hi_out == $past(req_addr_in[0]))
    else $error("byte write hit the wrong lane");
  AST_ERR_RAISE: assert property (direct && !req_byte_in && req_addr_in[0]
    |=> addr_err_out && addr_err_wr_out == $past(req_write_in))
    else $error("odd word access not flagged");
  AST_ERR_CAUSE: assert property (addr_err_out |->
    $past(req_valid_in) && !$past(req_byte_in))
    else $error("error without a word request");
  AST_ERR_NOWRITE: assert property (addr_err_out && addr_err_wr_out |->
    !ram_wr_lo_out && !ram_wr_hi_out)
    else $error("misaligned write reached memory");
  AST_EDS_WIN: assert property (full && !wr_bad && req_addr_in[15] &&
    req_addr_in[15:1] != 15'h4000 && req_addr_in[15:1] != 15'h4800
    |=> eds_en_out && !ram_en_out)
    else $error("upper half missed the window");
  AST_NEAR_FOLD: assert property (near_ram |=> ram_en_out &&
    ram_addr_out == {3'b000, $past(req_addr_in[12:1])})
    else $error("near field not folded onto ram");
  AST_SFR_HOLE: assert property (full && !req_write_in &&
    req_addr_in[15:5] == 11'h020 |=> !per_en_out ##1 rd_data_out == 16'h0000)
    else $error("empty region not zero");
endmodule
`default_nettype wire

/* File: dsau_mem_model.sv */
// Word memory model for one port of the access unit.
`timescale 1ns/1ps
`default_nettype none
module dsau_mem_model (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic wr_lo_in,
  input wire logic wr_hi_in,
  input wire logic [14:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [256];
  logic [15:0] last_r;
  // Preload each word's index to expose a wrong address.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hc000 | 16'(i);
    end
    last_r = 16'h0000;
  end
  // Off enable, show the inverse of the last word.
  assign rdata_out = en_in ? mem[addr_in[7:0]] : ~last_r;
  // Each lane writes under its own strobe; low lane is even.
  always @(posedge clk_in) begin
    if (en_in && wr_lo_in) begin
      mem[addr_in[7:0]][7:0] <= wdata_in[7:0];
    end
    if (en_in && wr_hi_in) begin
      mem[addr_in[7:0]][15:8] <= wdata_in[15:8];
    end
    if (en_in) begin
      last_r <= rdata_out;
    end
  end
endmodule
`default_nettype wire

/* File: dsau_tb.sv */
// Self-checking bench for the data-space access unit.
`timescale 1ns/1ps
`default_nettype none
module dsau_tb;
  import dsau_pkg::*;
  logic ref_clk_in, rstn_in = 1'b0;
  logic req_valid_in = 1'b0, req_write_in = 1'b0, req_byte_in = 1'b0;
  dsau_mode_type req_mode_in = DSAU_MODE_FULL;
  dsau_regop_type reg_op_in = DSAU_OP_NONE;
  logic [2:0] req_ptr_in = 3'd0, reg_sel_in = 3'd0, reg_rd_sel_in = 3'd0;
  logic [15:0] req_addr_in = 16'h0000, req_wdata_in = 16'h0000;
  logic [15:0] reg_data_in = 16'h0000, ram_rdata_in, per_rdata_in;
  logic [15:0] eds_rdata_in, ram_wdata_out, per_wdata_out, eds_wdata_out;
  logic [15:0] rd_data_out, reg_rdata_out, got_rd, got_reg;
  logic [14:0] ram_addr_out, per_addr_out, eds_addr_out, got_adr;
  logic ram_en_out, ram_wr_lo_out, ram_wr_hi_out, per_en_out, per_wr_lo_out;
  logic per_wr_hi_out, eds_en_out, eds_wr_lo_out, eds_wr_hi_out;
  logic rd_valid_out, addr_err_out, addr_err_wr_out;
  logic [2:0] got_en;
  logic [1:0] got_wr, got_err;
  int miscompares = 0, checks_done = 0, cycles = 0;
  dsau_top uut (.ref_clk_in, .rstn_in, .req_valid_in, .req_write_in,
    .req_byte_in, .req_mode_in, .req_ptr_in, .req_addr_in, .req_wdata_in,
    .reg_op_in, .reg_sel_in, .reg_data_in, .reg_rd_sel_in, .ram_rdata_in,
    .per_rdata_in, .eds_rdata_in, .ram_en_out, .ram_wr_lo_out,
    .ram_wr_hi_out, .ram_addr_out, .ram_wdata_out, .per_en_out,
    .per_wr_lo_out, .per_wr_hi_out, .per_addr_out, .per_wdata_out,
    .eds_en_out, .eds_wr_lo_out, .eds_wr_hi_out, .eds_addr_out,
    .eds_wdata_out, .rd_valid_out, .rd_data_out, .reg_rdata_out,
    .addr_err_out, .addr_err_wr_out);
  // RAM and control port models; the window is a constant.
  dsau_mem_model ram_mem (.clk_in(ref_clk_in), .en_in(ram_en_out),
    .wr_lo_in(ram_wr_lo_out), .wr_hi_in(ram_wr_hi_out),
    .addr_in(ram_addr_out), .wdata_in(ram_wdata_out), .rdata_out(ram_rdata_in));
  dsau_mem_model per_mem (.clk_in(ref_clk_in), .en_in(per_en_out),
    .wr_lo_in(per_wr_lo_out), .wr_hi_in(per_wr_hi_out),
    .addr_in(per_addr_out), .wdata_in(per_wdata_out), .rdata_out(per_rdata_in));
  assign eds_rdata_in = 16'h3c3c;
  // Clock, and a hang guard far above the run's length.
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end
  // ------
  // Shared tasks; all are entered just after a falling edge, except close_out when the hang guard calls it on a rising edge.
  // ------
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One access: ports seen in cycle 1, read data in cycle 2.
  task automatic acc(input logic w, input logic b, input dsau_mode_type m,
    input logic [15:0] a = 16'h0000, input logic [15:0] d = 16'h0000);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_byte_in = b;
    req_mode_in = m;
    req_addr_in = a;
    req_wdata_in = d;
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    got_en = {eds_en_out, per_en_out, ram_en_out};
    got_wr = {ram_wr_hi_out, ram_wr_lo_out};
    got_err = {addr_err_out, addr_err_wr_out};
    got_adr = ram_addr_out;
    @(negedge ref_clk_in);
    got_rd = rd_data_out;
  endtask
  task automatic regop(input dsau_regop_type op, input logic [2:0] s,
    input logic [15:0] d);
    reg_op_in = op;
    reg_sel_in = s;
    reg_data_in = d;
    @(negedge ref_clk_in);
    reg_op_in = DSAU_OP_NONE;
  endtask
  task automatic rdreg(input logic [2:0] s);
    reg_rd_sel_in = s;
    @(negedge ref_clk_in);
    got_reg = reg_rdata_out;
  endtask
  // Scenarios.
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rdreg(3'(i));
      check("reg reset", got_reg, 16'h0000);
    end
  endtask
  task automatic t_lanes;
    acc(1'b1, 1'b0, DSAU_MODE_FULL, 16'h0800, 16'h1234);
    check("word strobes", 16'(got_wr), 16'h0003);
    check("word addr", 16'(got_adr), 16'h0400);
    acc(1'b1, 1'b1, DSAU_MODE_FULL, 16'h0801, 16'h00ab);
    check("byte strobes", 16'(got_wr), 16'h0002);
    acc(1'b0, 1'b1, DSAU_MODE_FULL, 16'h0801);
    check("odd byte", got_rd, 16'h00ab);
    acc(1'b0, 1'b1, DSAU_MODE_FULL, 16'h0800);
    check("even byte", got_rd, 16'h0034);
  endtask
  task automatic t_misalign;
    acc(1'b1, 1'b0, DSAU_MODE_FULL, 16'h0801, 16'hffff);
    check("write error", 16'(got_err), 16'h0003);
    check("write blocked", 16'(got_wr), 16'h0000);
    acc(1'b0, 1'b0, DSAU_MODE_NEAR, 16'h0801);
    check("read error", 16'(got_err), 16'h0002);
    check("read done", got_rd, 16'hab34);
  endtask
  task automatic t_postinc;
    regop(DSAU_OP_LOAD_WORD, 3'd3, 16'h0810);
    req_ptr_in = 3'd3;
    acc(1'b0, 1'b1, DSAU_MODE_POSTINC);
    acc(1'b0, 1'b1, DSAU_MODE_POSTINC);
    acc(1'b0, 1'b0, DSAU_MODE_POSTINC);
    acc(1'b0, 1'b0, DSAU_MODE_INDIRECT);
    check("pointer ea", 16'(got_adr), 16'h040a);
  endtask
  task automatic t_extend;
    regop(DSAU_OP_LOAD_WORD, 3'd1, 16'h1234);
    regop(DSAU_OP_LOAD_BYTE, 3'd1, 16'hbbf5);
    rdreg(3'd1);
    check("byte load", got_reg, 16'h12f5);
    regop(DSAU_OP_SIGN_EXT, 3'd1, 16'h0000);
    rdreg(3'd1);
    check("sign ext", got_reg, 16'hfff5);
    regop(DSAU_OP_ZERO_EXT, 3'd1, 16'h0000);
    rdreg(3'd1);
    check("zero ext", got_reg, 16'h00f5);
  endtask
  task automatic t_regions;
    acc(1'b0, 1'b0, DSAU_MODE_NEAR, 16'he800);
    check("near data", got_rd, 16'hab34);
    acc(1'b0, 1'b0, DSAU_MODE_FULL, 16'he800);
    check("far data", got_rd, 16'h3c3c);
    acc(1'b0, 1'b0, DSAU_MODE_FULL, 16'h0020);
    check("sfr data", got_rd, 16'hc010);
    acc(1'b0, 1'b0, DSAU_MODE_FULL, 16'h0400);
    check("hole enables", 16'(got_en), 16'h0000);
    acc(1'b0, 1'b0, DSAU_MODE_FULL, 16'h27fe);
    check("ram top", 16'(got_en), 16'h0001);
    acc(1'b0, 1'b0, DSAU_MODE_FULL, 16'h2800);
    check("gap data", got_rd, 16'h0000);
    acc(1'b1, 1'b0, DSAU_MODE_FULL, 16'h9000, 16'h5a5a);
    rdreg(3'd3);
    check("mapped write", got_reg, 16'h5a5a);
  endtask
  // Reset, then the scenarios.
  initial begin
    repeat (8) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    @(negedge ref_clk_in);
    t_reset();
    t_lanes();
    t_misalign();
    t_postinc();
    t_extend();
    t_regions();
    close_out();
  end
endmodule
bind dsau_top dsau_checker chk (.ref_clk_in, .rstn_in, .req_valid_in,
  .req_write_in, .req_byte_in, .req_mode_in, .req_addr_in, .ram_en_out,
  .ram_wr_lo_out, .ram_wr_hi_out, .ram_addr_out, .per_en_out, .eds_en_out,
  .rd_valid_out, .rd_data_out, .addr_err_out, .addr_err_wr_out);
`default_nettype wire
